// file: iod_defs.svh
// Opcode patterns, masks and field positions for the instruction decoder
`ifndef IOD_DEFS_SVH
`define IOD_DEFS_SVH
`define IOD_OP_SEG_LOAD 8'h8E
`define IOD_OP_SEG_STORE 8'h8C
`define IOD_OP_PLUS_MASK 8'hFC
`define IOD_OP_PLUS 8'h00
`define IOD_OP_MINUS 8'h28
`define IOD_OP_MINUS_B 8'h18
`define IOD_OP_FIX_PROD 8'hD4
`define IOD_OP_FIX_QUOT 8'hD5
`define IOD_FIX_BASE 8'h0A
`define IOD_OP_AAPLUS 8'h37
`define IOD_OP_BCDPLUS 8'h27
`define IOD_OP_AAMINUS 8'h3F
`define IOD_OP_BCDMINUS 8'h2F
`define IOD_OP_BW_EXT 8'h98
`define IOD_OP_WD_EXT 8'h99
`define IOD_OP_SHIFT_MASK 8'hFC
`define IOD_OP_SHIFT 8'hD0
`define IOD_OP_GRP3_MASK 8'hFE
`define IOD_OP_GRP3 8'hF6
`define IOD_OP_FL_TO_AH 8'h9F
`define IOD_OP_AH_TO_FL 8'h9E
`define IOD_OP_FL_PUSH 8'h9C
`define IOD_OP_FL_POP 8'h9D
`define IOD_OP_TABLE_LOOKUP_BYTE 8'hD7
`define IOD_OP_LDS 8'hC5
`define IOD_OP_LES 8'hC4
`define IOD_OP_EA 8'h8D
`define IOD_OP_IMM_RM_MASK 8'hFE
`define IOD_OP_IMM_RM 8'hC6
`define IOD_BIT_W 0
`define IOD_BIT_D 1
`define IOD_BIT_SEG0 5
`define IOD_REG_HI 5
`define IOD_REG_LO 3
`endif

// file: iod_pkg.sv
// Types shared by the instruction decoder files
`default_nettype none
package iod_pkg;
  typedef enum {
    iod_none, transfer_op, seg_load, seg_store, plus_op, minus_op, minus_with_borrow,
    ascii_fix_after_product, ascii_fix_before_quotient, ascii_fix_after_plus,
    bcd_fix_after_plus, ascii_fix_after_minus, bcd_fix_after_minus,
    byte_to_word_extend, word_to_double_extend, left_rotate, right_rotate,
    left_shift, logical_right_shift, arithmetic_right_shift, bitwise_invert,
    sign_change, unsigned_product, signed_product, unsigned_quotient,
    signed_quotient, flags_to_high_acc, high_acc_to_flags, flags_to_stack,
    stack_to_flags, table_lookup_byte, load_far_pointer_data_seg,
    far_pointer_extra_seg, effective_address_load, iod_illegal
  } iod_op_t;
  typedef enum {iod_cls_single, iod_cls_modrm, iod_cls_group, iod_cls_fixed, iod_cls_bad}
    iod_cls_t;
endpackage
`default_nettype wire

// file: iod_first_class.sv
// First-byte classifier: what follows the opcode and the direct operation
`default_nettype none
`include "iod_defs.svh"
module iod_first_class
  import iod_pkg::*;
(
  // Opcode in
  input wire logic [7:0] op,
  // Classification out
  output iod_cls_t cls,
  output iod_op_t direct_op,
  output logic [7:0] imm_bytes
);
  always_comb begin
    cls = iod_cls_bad;
    direct_op = iod_illegal;
    imm_bytes = 8'h00;
    case (op)
      `IOD_OP_SEG_LOAD: begin cls = iod_cls_modrm; direct_op = seg_load; end
      `IOD_OP_SEG_STORE: begin cls = iod_cls_modrm; direct_op = seg_store; end
      `IOD_OP_FIX_PROD: begin cls = iod_cls_fixed; direct_op = ascii_fix_after_product; end
      `IOD_OP_FIX_QUOT: begin cls = iod_cls_fixed; direct_op = ascii_fix_before_quotient; end
      `IOD_OP_AAPLUS: begin cls = iod_cls_single; direct_op = ascii_fix_after_plus; end
      `IOD_OP_BCDPLUS: begin cls = iod_cls_single; direct_op = bcd_fix_after_plus; end
      `IOD_OP_AAMINUS: begin cls = iod_cls_single; direct_op = ascii_fix_after_minus; end
      `IOD_OP_BCDMINUS: begin cls = iod_cls_single; direct_op = bcd_fix_after_minus; end
      `IOD_OP_BW_EXT: begin cls = iod_cls_single; direct_op = byte_to_word_extend; end
      `IOD_OP_WD_EXT: begin cls = iod_cls_single; direct_op = word_to_double_extend; end
      `IOD_OP_FL_TO_AH: begin cls = iod_cls_single; direct_op = flags_to_high_acc; end
      `IOD_OP_AH_TO_FL: begin cls = iod_cls_single; direct_op = high_acc_to_flags; end
      `IOD_OP_FL_PUSH: begin cls = iod_cls_single; direct_op = flags_to_stack; end
      `IOD_OP_FL_POP: begin cls = iod_cls_single; direct_op = stack_to_flags; end
      `IOD_OP_TABLE_LOOKUP_BYTE: begin cls = iod_cls_single; direct_op = table_lookup_byte; end
      `IOD_OP_LDS: begin cls = iod_cls_modrm; direct_op = load_far_pointer_data_seg; end
      `IOD_OP_LES: begin cls = iod_cls_modrm; direct_op = far_pointer_extra_seg; end
      `IOD_OP_EA: begin cls = iod_cls_modrm; direct_op = effective_address_load; end
      default: begin
        if ((op & `IOD_OP_PLUS_MASK) == `IOD_OP_PLUS) begin
          cls = iod_cls_modrm;
          direct_op = plus_op;
        end else if ((op & `IOD_OP_PLUS_MASK) == `IOD_OP_MINUS) begin
          cls = iod_cls_modrm;
          direct_op = minus_op;
        end else if ((op & `IOD_OP_PLUS_MASK) == `IOD_OP_MINUS_B) begin
          cls = iod_cls_modrm;
          direct_op = minus_with_borrow;
        end else if ((op & `IOD_OP_SHIFT_MASK) == `IOD_OP_SHIFT) begin
          cls = iod_cls_group;
        end else if ((op & `IOD_OP_GRP3_MASK) == `IOD_OP_GRP3) begin
          cls = iod_cls_group;
        end else if ((op & `IOD_OP_IMM_RM_MASK) == `IOD_OP_IMM_RM) begin
          cls = iod_cls_group;
          // Second data byte only for word width
          imm_bytes = op[`IOD_BIT_W] ? 8'h02 : 8'h01;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// file: iod_group_sel.sv
// Group opcode resolver: picks the operation from the reg field
`default_nettype none
`include "iod_defs.svh"
module iod_group_sel
  import iod_pkg::*;
(
  // Inputs
  input wire logic [7:0] op,
  input wire logic [7:0] spec,
  // Result
  output iod_op_t grp_op
);
  logic [2:0] fld;
  assign fld = spec[`IOD_REG_HI:`IOD_REG_LO];
  always_comb begin
    grp_op = iod_illegal;
    if ((op & `IOD_OP_SHIFT_MASK) == `IOD_OP_SHIFT) begin
      case (fld)
        3'h0: grp_op = left_rotate;
        3'h1: grp_op = right_rotate;
        3'h4: grp_op = left_shift;
        3'h5: grp_op = logical_right_shift;
        3'h7: grp_op = arithmetic_right_shift;
        default: grp_op = iod_illegal;
      endcase
    end else if ((op & `IOD_OP_GRP3_MASK) == `IOD_OP_GRP3) begin
      case (fld)
        3'h2: grp_op = bitwise_invert;
        3'h3: grp_op = sign_change;
        3'h4: grp_op = unsigned_product;
        3'h5: grp_op = signed_product;
        3'h6: grp_op = unsigned_quotient;
        3'h7: grp_op = signed_quotient;
        default: grp_op = iod_illegal;
      endcase
    end else if ((op & `IOD_OP_IMM_RM_MASK) == `IOD_OP_IMM_RM) begin
      grp_op = (fld == 3'h0) ? transfer_op : iod_illegal;
    end
  end
endmodule
`default_nettype wire

// file: iod_decoder.sv
// Instruction opcode decoder: byte stream in, decoded operation out
//
// Notes on behaviour
// - 8E with spec bit5 zero: load segment
// - 8C plus spec: store segment register
// - 000000dw plus spec: plus_op
// - 001010dw minus, 000110dw minus with borrow
// - D4 then 0A: ascii fix after product
// - D5 then 0A: ascii fix before quotient
// - Four single-byte adjust opcodes
// - 98 and 99: sign extensions, single byte
// - Shift group op chosen by reg field
// - F6/F7 group op chosen by reg field
// - Four single-byte flag transfer opcodes
// - D7: table lookup, single byte
// - C5 and C4 far pointer loads, spec follows
// - 8D plus spec: effective address load
`default_nettype none
`include "iod_defs.svh"
module iod_decoder
  import iod_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Instruction byte stream
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // Decoded instruction
  output logic dec_valid_r,
  output iod_op_t dec_op_r,
  output logic dec_word_r,
  output logic dec_dir_r,
  output logic dec_shift_cl_r,
  output logic [2:0] dec_reg_r,
  output logic [1:0] dec_mod_r,
  output logic [2:0] dec_rm_r,
  output logic [15:0] dec_imm_r,
  output logic dec_busy_r
);
  typedef enum {st_first, st_spec, st_fixed, st_imm_lo, st_imm_hi} iod_state_t;

  iod_state_t state_r;
  logic [7:0] op_r;
  logic [7:0] spec_r;
  iod_cls_t cls;
  iod_op_t direct_op;
  iod_op_t grp_op;
  logic [7:0] imm_bytes;
  logic [7:0] imm_left_r;
  iod_op_t direct_r;

  iod_first_class u_class (
    .op(byte_data),
    .cls(cls),
    .direct_op(direct_op),
    .imm_bytes(imm_bytes)
  );

  iod_group_sel u_group (
    .op(op_r),
    .spec(byte_data),
    .grp_op(grp_op)
  );

  // Sequencer and captured bytes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= st_first;
      op_r <= 8'h00;
      spec_r <= 8'h00;
      direct_r <= iod_none;
      imm_left_r <= 8'h00;
    end else if (byte_valid) begin
      case (state_r)
        st_first: begin
          op_r <= byte_data;
          direct_r <= direct_op;
          imm_left_r <= imm_bytes;
          case (cls)
            iod_cls_modrm: state_r <= st_spec;
            iod_cls_group: state_r <= st_spec;
            iod_cls_fixed: state_r <= st_fixed;
            default: state_r <= st_first;
          endcase
        end
        st_spec: begin
          spec_r <= byte_data;
          state_r <= (imm_left_r != 8'h00) ? st_imm_lo : st_first;
        end
        st_fixed: state_r <= st_first;
        st_imm_lo: state_r <= (imm_left_r == 8'h02) ? st_imm_hi : st_first;
        st_imm_hi: state_r <= st_first;
        default: state_r <= st_first;
      endcase
    end
  end

  // Operation outcome
  iod_op_t op_nxt;
  logic fin_nxt;
  always_comb begin
    op_nxt = iod_none;
    fin_nxt = 1'b0;
    if (byte_valid) begin
      case (state_r)
        st_first: begin
          if (cls == iod_cls_single || cls == iod_cls_bad) begin
            fin_nxt = 1'b1;
            op_nxt = direct_op;
          end
        end
        st_spec: begin
          if (direct_r == seg_load) begin
            op_nxt = byte_data[`IOD_BIT_SEG0] ? iod_illegal : seg_load;
          end else if (direct_r == iod_illegal) begin
            op_nxt = grp_op;
          end else begin
            op_nxt = direct_r;
          end
          fin_nxt = (imm_left_r == 8'h00);
        end
        st_fixed: begin
          fin_nxt = 1'b1;
          op_nxt = (byte_data == `IOD_FIX_BASE) ? direct_r : iod_illegal;
        end
        st_imm_lo: begin
          fin_nxt = (imm_left_r != 8'h02);
          op_nxt = transfer_op;
        end
        st_imm_hi: begin
          fin_nxt = 1'b1;
          op_nxt = transfer_op;
        end
        default: begin
          fin_nxt = 1'b0;
          op_nxt = iod_none;
        end
      endcase
    end
  end

  // Pending operation held across immediate bytes
  iod_op_t pend_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_r <= iod_none;
    end else if (byte_valid && state_r == st_spec) begin
      pend_r <= op_nxt;
    end
  end

  // Result registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_valid_r <= 1'b0;
      dec_op_r <= iod_none;
    end else begin
      dec_valid_r <= fin_nxt;
      if (fin_nxt) begin
        dec_op_r <= (state_r == st_imm_lo || state_r == st_imm_hi) ? pend_r : op_nxt;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_word_r <= 1'b0;
      dec_dir_r <= 1'b0;
      dec_shift_cl_r <= 1'b0;
    end else if (byte_valid && state_r == st_first) begin
      // Fixed-width opcodes report their low bits too; only width-bearing ones matter
      dec_word_r <= byte_data[`IOD_BIT_W];
      dec_dir_r <= byte_data[`IOD_BIT_D];
      dec_shift_cl_r <= byte_data[`IOD_BIT_D];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_reg_r <= 3'h0;
      dec_mod_r <= 2'h0;
      dec_rm_r <= 3'h0;
    end else if (byte_valid && state_r == st_first) begin
      dec_reg_r <= 3'h0;
      dec_mod_r <= 2'h0;
      dec_rm_r <= 3'h0;
    end else if (byte_valid && state_r == st_spec) begin
      dec_mod_r <= byte_data[7:6];
      dec_reg_r <= byte_data[`IOD_REG_HI:`IOD_REG_LO];
      dec_rm_r <= byte_data[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_imm_r <= 16'h0000;
    end else if (byte_valid && state_r == st_first) begin
      dec_imm_r <= 16'h0000;
    end else if (byte_valid && state_r == st_imm_lo) begin
      dec_imm_r <= {8'h00, byte_data};
    end else if (byte_valid && state_r == st_imm_hi) begin
      dec_imm_r <= {byte_data, dec_imm_r[7:0]};
    end
  end

  // Busy while inside a multi-byte instruction
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_busy_r <= 1'b0;
    end else if (byte_valid) begin
      dec_busy_r <= !fin_nxt;
    end
  end
endmodule
`default_nettype wire

// file: iod_byte_feed.sv
// Instruction byte source standing in for the prefetch queue
`default_nettype none
module iod_byte_feed
(
  // Clock
  input wire logic ref_clk,
  // Byte stream
  output logic byte_valid,
  output logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'hA5;
  end
  // Entered just after an edge; byte held through the taking edge
  task automatic send(input logic [7:0] b);
    byte_valid = 1'b1;
    byte_data = b;
    @(posedge ref_clk);
    #1;
  endtask
  // Idle data toggles so a stale byte never looks like a fresh one
  task automatic idle(input int n);
    byte_valid = 1'b0;
    repeat (n) begin
      byte_data = ~byte_data;
      @(posedge ref_clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// file: iod_decoder_props.sv
// Assertions on the decoder ports
`default_nettype none
module iod_decoder_props
  import iod_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Byte stream
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // Decode result
  input wire logic dec_valid_r,
  input var iod_op_t dec_op_r,
  input wire logic dec_word_r,
  input wire logic [2:0] dec_reg_r,
  input wire logic dec_busy_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Idle decoder means the byte opens an instruction
  wire logic first_w = byte_valid && !dec_busy_r;
  AST_SEG_LOAD:
    assert property (first_w && byte_data == 8'h8E ##1 byte_valid && !byte_data[5]
      |=> dec_valid_r && dec_op_r == seg_load) else $error("segment load missed");
  AST_SEG_STORE:
    assert property (first_w && byte_data == 8'h8C ##1 byte_valid
      |=> dec_valid_r && dec_op_r == seg_store) else $error("segment store missed");
  AST_PLUS:
    assert property (first_w && byte_data[7:2] == 6'h00 ##1 byte_valid
      |=> dec_op_r == plus_op) else $error("plus form missed");
  AST_FIX_PROD:
    assert property (first_w && byte_data == 8'hD4 ##1 byte_valid && byte_data == 8'h0A
      |=> dec_valid_r && dec_op_r == ascii_fix_after_product) else $error("fix missed");
  AST_EXTEND:
    assert property (first_w && byte_data == 8'h98
      |=> dec_valid_r && dec_op_r == byte_to_word_extend && !dec_word_r)
      else $error("extend missed");
  AST_LOOKUP:
    assert property (first_w && byte_data == 8'hD7
      |=> dec_op_r == table_lookup_byte && !dec_busy_r) else $error("lookup missed");
  AST_FAR_BUSY:
    assert property (first_w && byte_data == 8'hC5 |=> dec_busy_r && !dec_valid_r)
      else $error("far pointer ended early");
  AST_LEA:
    assert property (first_w && byte_data == 8'h8D ##1 byte_valid
      |=> dec_op_r == effective_address_load && dec_reg_r == 3'($past(byte_data) >> 3))
      else $error("address load wrong");
  AST_WORD_IMM:
    assert property (first_w && byte_data == 8'hC7 ##1 byte_valid ##1 byte_valid
      |=> dec_busy_r && !dec_valid_r) else $error("word immediate cut short");
  cover property (dec_valid_r && dec_op_r == iod_illegal);
  cover property (first_w && byte_data == 8'hD5);
  cover property (dec_valid_r [*2]);
endmodule
bind iod_decoder iod_decoder_props iod_decoder_props_i (.ref_clk(ref_clk), .srst(srst),
  .byte_valid(byte_valid), .byte_data(byte_data), .dec_valid_r(dec_valid_r),
  .dec_op_r(dec_op_r), .dec_word_r(dec_word_r), .dec_reg_r(dec_reg_r),
  .dec_busy_r(dec_busy_r));
`default_nettype wire

// file: tb_top.sv
// Testbench for the instruction opcode decoder
`default_nettype none
module tb_top import iod_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic byte_valid, dec_valid_r, dec_word_r, dec_dir_r, dec_shift_cl_r, dec_busy_r;
  logic [7:0] byte_data;
  iod_op_t dec_op_r;
  logic [2:0] dec_reg_r, dec_rm_r;
  logic [1:0] dec_mod_r;
  logic [15:0] dec_imm_r;
  int error_cnt = 0;
  int n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  iod_byte_feed iod_byte_feed_i (.ref_clk(ref_clk), .byte_valid(byte_valid),
    .byte_data(byte_data));
  iod_decoder iod_decoder_i (.ref_clk(ref_clk), .srst(srst), .byte_valid(byte_valid),
    .byte_data(byte_data), .dec_valid_r(dec_valid_r), .dec_op_r(dec_op_r),
    .dec_word_r(dec_word_r), .dec_dir_r(dec_dir_r), .dec_shift_cl_r(dec_shift_cl_r),
    .dec_reg_r(dec_reg_r), .dec_mod_r(dec_mod_r), .dec_rm_r(dec_rm_r),
    .dec_imm_r(dec_imm_r), .dec_busy_r(dec_busy_r));
  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_op(input string nm, input iod_op_t e, input iod_op_t g);
    n_compared++;
    if (e !== g) begin
      error_cnt++;
      $display("MISMATCH %s expected %s seen %s", nm, e.name(), g.name());
    end
  endtask
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (e !== g) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bytes go back to back; valid and busy checked after each byte, op just after the edge that takes the last
  task automatic instr(input logic [7:0] b [4], input int n, input iod_op_t e);
    for (int i = 0; i < n; i++) begin
      iod_byte_feed_i.send(b[i]);
      chk_val("valid", 16'(i == n - 1), 16'(dec_valid_r));
      chk_val("busy", 16'(i != n - 1), 16'(dec_busy_r));
    end
    chk_op("op", e, dec_op_r);
  endtask
  task automatic fld(input logic [9:0] e);
    chk_val("fields", 16'(e), 16'({dec_dir_r, dec_word_r, dec_reg_r, dec_mod_r, dec_rm_r}));
  endtask
  task automatic t_single();
    logic [7:0] c [11] = '{8'h98, 8'h99, 8'h37, 8'h27, 8'h3F, 8'h2F, 8'h9F, 8'h9E, 8'h9C,
      8'h9D, 8'hD7};
    iod_op_t o [11] = '{byte_to_word_extend, word_to_double_extend, ascii_fix_after_plus,
      bcd_fix_after_plus, ascii_fix_after_minus, bcd_fix_after_minus, flags_to_high_acc,
      high_acc_to_flags, flags_to_stack, stack_to_flags, table_lookup_byte};
    for (int i = 0; i < 11; i++) begin
      instr('{c[i], 8'h00, 8'h00, 8'h00}, 1, o[i]);
      fld({c[i][1:0], 8'h00});
    end
  endtask
  task automatic t_modrm();
    logic [7:0] c [12] = '{8'h8E, 8'h8E, 8'h8C, 8'h00, 8'h03, 8'h29, 8'h2A, 8'h18, 8'h1B,
      8'hC5, 8'hC4, 8'h8D};
    logic [7:0] s [12] = '{8'h5A, 8'h20, 8'hD8, 8'hC1, 8'h4A, 8'h13, 8'hE5, 8'h2C, 8'hF7,
      8'h96, 8'h0E, 8'h1E};
    iod_op_t o [12] = '{seg_load, iod_illegal, seg_store, plus_op, plus_op, minus_op,
      minus_op, minus_with_borrow, minus_with_borrow, load_far_pointer_data_seg,
      far_pointer_extra_seg, effective_address_load};
    for (int i = 0; i < 12; i++) begin
      instr('{c[i], s[i], 8'h00, 8'h00}, 2, o[i]);
      if (o[i] != iod_illegal) fld({c[i][1:0], s[i][5:3], s[i][7:6], s[i][2:0]});
    end
    iod_byte_feed_i.idle(2);
  endtask
  task automatic t_fix();
    instr('{8'hD4, 8'h0A, 8'h00, 8'h00}, 2, ascii_fix_after_product);
    instr('{8'hD4, 8'h0B, 8'h00, 8'h00}, 2, iod_illegal);
    instr('{8'hD5, 8'h0A, 8'h00, 8'h00}, 2, ascii_fix_before_quotient);
    instr('{8'hD5, 8'h00, 8'h00, 8'h00}, 2, iod_illegal);
  endtask
  task automatic t_group();
    iod_op_t sh [8] = '{left_rotate, right_rotate, iod_illegal, iod_illegal, left_shift,
      logical_right_shift, iod_illegal, arithmetic_right_shift};
    iod_op_t g3 [8] = '{iod_illegal, iod_illegal, bitwise_invert, sign_change,
      unsigned_product, signed_product, unsigned_quotient, signed_quotient};
    logic [7:0] b;
    for (int r = 0; r < 8; r++) begin
      b = 8'hD0 | 8'(r % 4);
      instr('{b, {2'b11, 3'(r), 3'b010}, 8'h00, 8'h00}, 2, sh[r]);
      if (sh[r] != iod_illegal) chk_val("count_cl", 16'(b[1]), 16'(dec_shift_cl_r));
      b = 8'hF6 | 8'(r % 2);
      instr('{b, {2'b11, 3'(r), 3'b110}, 8'h00, 8'h00}, 2, g3[r]);
      if (g3[r] != iod_illegal) chk_val("word", 16'(b[0]), 16'(dec_word_r));
    end
  endtask
  task automatic t_imm();
    instr('{8'hC6, 8'h05, 8'h34, 8'h00}, 3, transfer_op);
    chk_val("imm_lo", 16'h0034, 16'(dec_imm_r[7:0]));
    instr('{8'hC7, 8'hC0, 8'h34, 8'h12}, 4, transfer_op);
    chk_val("imm", 16'h1234, dec_imm_r);
  endtask
  // Gap inside an instruction, then a reset that aborts a half-taken one
  task automatic t_gap();
    iod_byte_feed_i.send(8'h8D);
    iod_byte_feed_i.idle(3);
    chk_val("busy_gap", 16'h0001, 16'(dec_busy_r));
    instr('{8'h1E, 8'h00, 8'h00, 8'h00}, 1, effective_address_load);
    fld(10'h166);
    iod_byte_feed_i.send(8'hD4);
    iod_byte_feed_i.idle(1);
    srst = 1'b1;
    @(posedge ref_clk);
    #1 srst = 1'b0;
    chk_op("op_rst", iod_none, dec_op_r);
    chk_val("busy_rst", 16'h0000, 16'(dec_busy_r));
    instr('{8'h98, 8'h00, 8'h00, 8'h00}, 1, byte_to_word_extend);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 srst = 1'b0;
    t_single();
    t_modrm();
    t_fix();
    t_group();
    t_imm();
    t_gap();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
